// [hdl/bfsr_pkg.sv]
// Constants of the battery fault status register bank.
// Assumes a 200 MHz clock and an Avalon-MM master using byte addresses.
// Summary of operation
// [R1] Writing 1 to a summary bit clears every flag of that category.
// [R2] Summary bit reads 1 while any flag of its category is set.
// [R3] Summary bits follow live flags, latched or self-clearing alike.
// [R4] Bits: cells 15/14, aux 13/12, comparators 11/10, link 9, system 8, silicon 7, pins 6.
// [R5] Summary bits 5 to 0 always read zero.
// [R6] In each flag register, writing 1 clears that flag; 0 leaves it.
// [R7] Cell low flag sets when a stored cell result is below the low threshold.
// [R8] Cell high flag sets when a stored cell result exceeds the high threshold.
// [R9] Aux low flags in bits 15..8, bit 8 for channel zero.
// [R10] Aux high flags in bits 7..0, bit 0 for channel zero.
// [R11] With auto-clear, cell and aux flags clear once the condition disappears.
// [R12] Comparator low flag sets when that cell's comparator reports undervoltage.
// [R13] With auto-clear, comparator flags clear only while no other analog fault is set.
// [R14] The analog fault check ignores masking of the fault output.
// [R15] Analog faults: system bits 0..3 and all comparator low and high flags.
// [R16] Without auto-clear, flags stay set until software clears them.
// [R17] Cell and aux comparison happens when a new result is stored.
package bfsr_pkg;
	// ----------------------------------------
	// Register indices, byte address is four times
	// ----------------------------------------
	localparam logic [7:0] IDX_SUMMARY   = 8'h52;
	localparam logic [7:0] IDX_CELL_LOW  = 8'h54;
	localparam logic [7:0] IDX_CELL_HIGH = 8'h56;
	localparam logic [7:0] IDX_AUX       = 8'h58;
	localparam logic [7:0] IDX_CMP_LOW   = 8'h5A;
	localparam logic [7:0] IDX_CONFIG    = 8'h60;
	localparam logic [7:0] IDX_IRQ_STAT  = 8'h61;
	localparam logic [7:0] IDX_IRQ_MASK  = 8'h62;
	localparam logic [7:0] IDX_CELL_LTH  = 8'h63;
	localparam logic [7:0] IDX_CELL_HTH  = 8'h64;
	localparam logic [7:0] IDX_AUX_LTH   = 8'h68;
	localparam logic [7:0] IDX_AUX_HTH   = 8'h70;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int SUM_CELL_LOW  = 15;
	localparam int SUM_CELL_HIGH = 14;
	localparam int SUM_AUX_LOW   = 13;
	localparam int SUM_AUX_HIGH  = 12;
	localparam int SUM_CMP_LOW   = 11;
	localparam int SUM_CMP_HIGH  = 10;
	localparam int SUM_LINK      = 9;
	localparam int SUM_SYSTEM    = 8;
	localparam int SUM_SILICON   = 7;
	localparam int SUM_PINS      = 6;
	localparam int AUX_LOW_LSB   = 8;
	localparam int CFG_AUTOCLEAR = 0;
	localparam int NUM_CELLS     = 16;
	localparam int NUM_AUX       = 8;
	localparam int NUM_EVENTS    = 5;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [15:0] RST_FLAGS     = 16'h0000;
	localparam logic [15:0] RST_CELL_LTH  = 16'h0000;
	localparam logic [15:0] RST_CELL_HTH  = 16'hFFFF;
	localparam logic [15:0] RST_AUX_LTH   = 16'h0000;
	localparam logic [15:0] RST_AUX_HTH   = 16'hFFFF;
	localparam logic [4:0]  RST_IRQ       = 5'h00;
	localparam logic        RST_AUTOCLEAR = 1'b0;
endpackage

// [hdl/bfsr_regs.sv]
// Fault status register bank: cell, aux and comparator flags with summary.
// Assumes results, external fault levels and comparator_high_any arrive on clk;
// comparator low outputs come from the analog side and are synchronised here.
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps
module bfsr_regs (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic [9:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        result_valid,
	input  wire logic        result_is_aux,
	input  wire logic [3:0]  result_channel,
	input  wire logic [15:0] result_value,
	input  wire logic [15:0] comparator_low_in,
	input  wire logic        comparator_high_any,
	input  wire logic [3:0]  system_analog_faults,
	input  wire logic        link_error_any,
	input  wire logic        system_fault_any,
	input  wire logic        silicon_fault_any,
	input  wire logic        input_pin_fault_any,
	output logic      [4:0]  category_clear,
	output logic             irq
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [15:0] cell_low_q, cell_low_d;
	logic [15:0] cell_high_q, cell_high_d;
	logic [15:0] aux_q, aux_d;
	logic [15:0] cmp_low_q, cmp_low_d;
	logic [15:0] cmp_sync1_q, cmp_sync2_q;
	logic [15:0] cell_lth_q, cell_hth_q;
	logic [15:0] aux_lth_q [bfsr_pkg::NUM_AUX];
	logic [15:0] aux_hth_q [bfsr_pkg::NUM_AUX];
	logic        autoclear_q;
	logic [4:0]  irq_stat_q, irq_stat_d, irq_mask_q;
	logic        wait_q;
	logic [31:0] rdata_q;
	logic [4:0]  cat_clr_q;
	logic        irq_q;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wire [7:0]  idx      = avs_address[9:2];
	wire        do_write = avs_write && !wait_q;
	wire [15:0] lane     = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	wire [15:0] wdata    = avs_writedata[15:0] & lane;
	wire        wr_sum   = do_write && (idx == bfsr_pkg::IDX_SUMMARY);
	wire        wr_cl    = do_write && (idx == bfsr_pkg::IDX_CELL_LOW);
	wire        wr_ch    = do_write && (idx == bfsr_pkg::IDX_CELL_HIGH);
	wire        wr_aux   = do_write && (idx == bfsr_pkg::IDX_AUX);
	wire        wr_cmp   = do_write && (idx == bfsr_pkg::IDX_CMP_LOW);
	wire        wr_cfg   = do_write && (idx == bfsr_pkg::IDX_CONFIG);
	wire        wr_ist   = do_write && (idx == bfsr_pkg::IDX_IRQ_STAT);
	wire        wr_imk   = do_write && (idx == bfsr_pkg::IDX_IRQ_MASK);
	wire        wr_clth  = do_write && (idx == bfsr_pkg::IDX_CELL_LTH);
	wire        wr_chth  = do_write && (idx == bfsr_pkg::IDX_CELL_HTH);
	wire        wr_alth  = do_write && (idx[7:3] == bfsr_pkg::IDX_AUX_LTH[7:3]);
	wire        wr_ahth  = do_write && (idx[7:3] == bfsr_pkg::IDX_AUX_HTH[7:3]);

	// Write-one clears, summary bits fan out to whole categories
	wire [15:0] sum_clr = wr_sum ? wdata : 16'h0000; // see [R1]
	wire [15:0] clr_cl  = (wr_cl ? wdata : 16'h0000)
		| {16{sum_clr[bfsr_pkg::SUM_CELL_LOW]}}; // see [R6]
	wire [15:0] clr_ch  = (wr_ch ? wdata : 16'h0000)
		| {16{sum_clr[bfsr_pkg::SUM_CELL_HIGH]}};
	wire [15:0] clr_aux = (wr_aux ? wdata : 16'h0000)
		| {{8{sum_clr[bfsr_pkg::SUM_AUX_LOW]}}, {8{sum_clr[bfsr_pkg::SUM_AUX_HIGH]}}};
	wire [15:0] clr_cmp = (wr_cmp ? wdata : 16'h0000)
		| {16{sum_clr[bfsr_pkg::SUM_CMP_LOW]}};

	// ----------------------------------------
	// Summary view
	// ----------------------------------------
	wire [15:0] summary = {
		|cell_low_q, |cell_high_q,
		|aux_q[15:bfsr_pkg::AUX_LOW_LSB], |aux_q[bfsr_pkg::AUX_LOW_LSB-1:0],
		|cmp_low_q, comparator_high_any, link_error_any,
		system_fault_any, silicon_fault_any, input_pin_fault_any,
		6'h00}; // see [R2] [R3] [R4] [R5]

	// ----------------------------------------
	// Flag update
	// ----------------------------------------
	wire [2:0]  aux_ch     = result_channel[2:0];
	wire        cell_store = result_valid && !result_is_aux; // see [R17]
	wire        aux_store  = result_valid && result_is_aux && !result_channel[3];
	wire        cell_below = result_value < cell_lth_q; // see [R7]
	wire        cell_above = result_value > cell_hth_q; // see [R8]
	wire        aux_below  = result_value < aux_lth_q[aux_ch];
	wire        aux_above  = result_value > aux_hth_q[aux_ch];
	// Masking of the fault output plays no part here
	wire        analog_ext = comparator_high_any || (|system_analog_faults); // see [R14] [R15]

	always_comb begin
		cell_low_d  = cell_low_q & ~clr_cl;
		cell_high_d = cell_high_q & ~clr_ch;
		aux_d       = aux_q & ~clr_aux;
		cmp_low_d   = cmp_low_q & ~clr_cmp;
		if (cell_store) begin
			// Stored result overrides a clear in the same cycle
			if (autoclear_q) begin
				cell_low_d[result_channel]  = cell_below; // see [R11]
				cell_high_d[result_channel] = cell_above;
			end else begin
				cell_low_d[result_channel]  = cell_low_d[result_channel] | cell_below; // see [R16]
				cell_high_d[result_channel] = cell_high_d[result_channel] | cell_above;
			end
		end
		if (aux_store) begin
			if (autoclear_q) begin
				aux_d[bfsr_pkg::AUX_LOW_LSB + aux_ch] = aux_below; // see [R9] [R11]
				aux_d[aux_ch]                          = aux_above; // see [R10]
			end else begin
				aux_d[bfsr_pkg::AUX_LOW_LSB + aux_ch] =
					aux_d[bfsr_pkg::AUX_LOW_LSB + aux_ch] | aux_below;
				aux_d[aux_ch] = aux_d[aux_ch] | aux_above;
			end
		end
		for (int i = 0; i < bfsr_pkg::NUM_CELLS; i++) begin
			if (cmp_sync2_q[i]) begin
				cmp_low_d[i] = 1'b1; // see [R12]
			end else if (autoclear_q && !analog_ext
				&& ((cmp_low_q & ~(16'h0001 << i)) == 16'h0000)) begin
				cmp_low_d[i] = 1'b0; // see [R13]
			end
		end
	end

	// New flags raise interrupt events; a new event beats a clear
	wire [4:0] events = {
		|(cmp_low_d & ~cmp_low_q),
		|(aux_d[bfsr_pkg::AUX_LOW_LSB-1:0] & ~aux_q[bfsr_pkg::AUX_LOW_LSB-1:0]),
		|(aux_d[15:bfsr_pkg::AUX_LOW_LSB] & ~aux_q[15:bfsr_pkg::AUX_LOW_LSB]),
		|(cell_high_d & ~cell_high_q),
		|(cell_low_d & ~cell_low_q)};
	assign irq_stat_d = (irq_stat_q & ~(wr_ist ? wdata[4:0] : 5'h00)) | events;

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	logic [15:0] rsel;
	always_comb begin
		if (idx == bfsr_pkg::IDX_SUMMARY) begin
			rsel = summary;
		end else if (idx == bfsr_pkg::IDX_CELL_LOW) begin
			rsel = cell_low_q;
		end else if (idx == bfsr_pkg::IDX_CELL_HIGH) begin
			rsel = cell_high_q;
		end else if (idx == bfsr_pkg::IDX_AUX) begin
			rsel = aux_q;
		end else if (idx == bfsr_pkg::IDX_CMP_LOW) begin
			rsel = cmp_low_q;
		end else if (idx == bfsr_pkg::IDX_CONFIG) begin
			rsel = {15'h0000, autoclear_q};
		end else if (idx == bfsr_pkg::IDX_IRQ_STAT) begin
			rsel = {11'h000, irq_stat_q};
		end else if (idx == bfsr_pkg::IDX_IRQ_MASK) begin
			rsel = {11'h000, irq_mask_q};
		end else if (idx == bfsr_pkg::IDX_CELL_LTH) begin
			rsel = cell_lth_q;
		end else if (idx == bfsr_pkg::IDX_CELL_HTH) begin
			rsel = cell_hth_q;
		end else if (idx[7:3] == bfsr_pkg::IDX_AUX_LTH[7:3]) begin
			rsel = aux_lth_q[idx[2:0]];
		end else if (idx[7:3] == bfsr_pkg::IDX_AUX_HTH[7:3]) begin
			rsel = aux_hth_q[idx[2:0]];
		end else begin
			rsel = 16'h0000;
		end
	end

	// ----------------------------------------
	// Sequential logic
	// ----------------------------------------
	// One wait cycle per access: data is captured while waitrequest is high
	always_ff @(posedge clk) begin
		if (reset) begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else begin
			wait_q  <= !(wait_q && (avs_read || avs_write));
			rdata_q <= {16'h0000, rsel};
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cmp_sync1_q <= 16'h0000;
			cmp_sync2_q <= 16'h0000;
		end else begin
			cmp_sync1_q <= comparator_low_in;
			cmp_sync2_q <= cmp_sync1_q;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cell_low_q  <= bfsr_pkg::RST_FLAGS;
			cell_high_q <= bfsr_pkg::RST_FLAGS;
			aux_q       <= bfsr_pkg::RST_FLAGS;
			cmp_low_q   <= bfsr_pkg::RST_FLAGS;
			irq_stat_q  <= bfsr_pkg::RST_IRQ;
			cat_clr_q   <= 5'h00;
			irq_q       <= 1'b0;
		end else begin
			cell_low_q  <= cell_low_d;
			cell_high_q <= cell_high_d;
			aux_q       <= aux_d;
			cmp_low_q   <= cmp_low_d;
			irq_stat_q  <= irq_stat_d;
			cat_clr_q   <= sum_clr[bfsr_pkg::SUM_CMP_HIGH:bfsr_pkg::SUM_PINS]; // see [R1]
			irq_q       <= |(irq_stat_d & irq_mask_q);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			autoclear_q <= bfsr_pkg::RST_AUTOCLEAR;
			irq_mask_q  <= bfsr_pkg::RST_IRQ;
			cell_lth_q  <= bfsr_pkg::RST_CELL_LTH;
			cell_hth_q  <= bfsr_pkg::RST_CELL_HTH;
		end else begin
			if (wr_cfg && avs_byteenable[0]) begin
				autoclear_q <= avs_writedata[bfsr_pkg::CFG_AUTOCLEAR];
			end
			if (wr_imk) begin
				irq_mask_q <= (irq_mask_q & ~lane[4:0]) | wdata[4:0];
			end
			if (wr_clth) begin
				cell_lth_q <= (cell_lth_q & ~lane) | wdata;
			end
			if (wr_chth) begin
				cell_hth_q <= (cell_hth_q & ~lane) | wdata;
			end
		end
	end

	always_ff @(posedge clk) begin
		for (int j = 0; j < bfsr_pkg::NUM_AUX; j++) begin
			if (reset) begin
				aux_lth_q[j] <= bfsr_pkg::RST_AUX_LTH;
				aux_hth_q[j] <= bfsr_pkg::RST_AUX_HTH;
			end else begin
				if (wr_alth && (idx[2:0] == 3'(j))) begin
					aux_lth_q[j] <= (aux_lth_q[j] & ~lane) | wdata;
				end
				if (wr_ahth && (idx[2:0] == 3'(j))) begin
					aux_hth_q[j] <= (aux_hth_q[j] & ~lane) | wdata;
				end
			end
		end
	end

	assign avs_readdata    = rdata_q;
	assign avs_waitrequest = wait_q;
	assign category_clear  = cat_clr_q;
	assign irq             = irq_q;
endmodule

// [testbench/bfsr_regs_sva.sv]
// Checker for the fault register bank: bus timing, summary and clear pulses.
// Assumes a master that holds each request until waitrequest is seen low.
`timescale 1ns/1ps
module bfsr_regs_sva (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic [9:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        result_valid,
	input wire logic        result_is_aux,
	input wire logic [3:0]  result_channel,
	input wire logic [15:0] result_value,
	input wire logic [15:0] comparator_low_in,
	input wire logic        comparator_high_any,
	input wire logic [3:0]  system_analog_faults,
	input wire logic        link_error_any,
	input wire logic        system_fault_any,
	input wire logic        silicon_fault_any,
	input wire logic        input_pin_fault_any,
	input wire logic [4:0]  category_clear,
	input wire logic        irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// ----------------------------------------
	// Bus steps
	// ----------------------------------------
	sequence req_start_s;
		$rose(avs_read || avs_write);
	endsequence
	sequence sum_read_s;
		avs_read && !avs_waitrequest && avs_address[9:2] == bfsr_pkg::IDX_SUMMARY;
	endsequence
	sequence sum_write_s;
		avs_write && !avs_waitrequest && avs_address[9:2] == bfsr_pkg::IDX_SUMMARY;
	endsequence
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	bus_answer_a: assert property (req_start_s |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("waitrequest not low one cycle after request");
	wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	wait_cause_a: assert property (!avs_waitrequest |-> (avs_read || avs_write)
		&& $past(avs_read || avs_write)) else $error("waitrequest low without request");
	upper_zero_a: assert property (avs_readdata[31:16] == 16'h0000)
		else $error("upper read data not zero");
	reserved_zero_a: assert property (sum_read_s |-> avs_readdata[5:0] == 6'h00)
		else $error("reserved summary bits not zero");
	ext_summary_a: assert property (sum_read_s |-> avs_readdata[10:6] ==
		$past({comparator_high_any, link_error_any, system_fault_any, silicon_fault_any,
		input_pin_fault_any})) else $error("summary bits 10 to 6 wrong");
	clear_pulse_a: assert property (sum_write_s |=> category_clear == $past(
		{avs_writedata[10:8] & {3{avs_byteenable[1]}}, avs_writedata[7:6] & {2{avs_byteenable[0]}}}))
		else $error("category clear pulse wrong");
	clear_cause_a: assert property (category_clear != 5'h00 |-> $past(avs_write
		&& !avs_waitrequest && avs_address[9:2] == bfsr_pkg::IDX_SUMMARY))
		else $error("stray clear pulse");
	reset_quiet_a: assert property ($past(reset) |-> avs_waitrequest && !irq
		&& category_clear == 5'h00) else $error("outputs not quiet after reset");
endmodule
bind bfsr_regs bfsr_regs_sva bfsr_regs_sva_i (.clk(clk), .reset(reset),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.result_valid(result_valid), .result_is_aux(result_is_aux),
	.result_channel(result_channel), .result_value(result_value),
	.comparator_low_in(comparator_low_in), .comparator_high_any(comparator_high_any),
	.system_analog_faults(system_analog_faults), .link_error_any(link_error_any),
	.system_fault_any(system_fault_any), .silicon_fault_any(silicon_fault_any),
	.input_pin_fault_any(input_pin_fault_any), .category_clear(category_clear), .irq(irq));

// [testbench/bfsr_regs_tb_top.sv]
// Self-checking bench for the fault register bank.
// Assumes the checker is bound in; byte enables are held all-on.
`timescale 1ns/1ps
module bfsr_regs_tb_top;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic [9:0]  avs_address = 10'h000;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        result_valid = 1'b0;
	logic        result_is_aux = 1'b0;
	logic [3:0]  result_channel = 4'h0;
	logic [15:0] result_value = 16'h0000;
	logic [15:0] cmp_low = 16'h0000;
	logic        cmp_high = 1'b0;
	logic [3:0]  sys_an = 4'h0;
	logic [3:0]  ext = 4'h0;
	logic [4:0]  cat_clr;
	logic        irq;
	int          err_count = 0;
	int          total_checks = 0;
	int          cycles = 0;
	logic [15:0] q;
	bfsr_regs bfsr_regs_i (.clk(clk), .reset(reset), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.result_valid(result_valid), .result_is_aux(result_is_aux),
		.result_channel(result_channel), .result_value(result_value),
		.comparator_low_in(cmp_low), .comparator_high_any(cmp_high),
		.system_analog_faults(sys_an), .link_error_any(ext[3]), .system_fault_any(ext[2]),
		.silicon_fault_any(ext[1]), .input_pin_fault_any(ext[0]), .category_clear(cat_clr),
		.irq(irq));
	always #2.5 clk = ~clk;
	// ----------------------------------------
	// Timeout and closing
	// ----------------------------------------
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish;
		$display("Checks %0d, mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Bus and stimulus helpers
	// ----------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Request held until the edge that sees waitrequest low
	task automatic bus(input logic w, input logic [7:0] idx, input logic [15:0] d);
		@(posedge clk);
		avs_write <= w;
		avs_read <= !w;
		avs_address <= {idx, 2'b00};
		avs_writedata <= {16'h0000, d};
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata[15:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] idx, input logic [15:0] exp);
		bus(1'b0, idx, 16'h0000);
		chk(q, exp);
	endtask
	task automatic store(input logic a, input logic [3:0] ch, input logic [15:0] v);
		@(posedge clk);
		result_valid <= 1'b1;
		result_is_aux <= a;
		result_channel <= ch;
		result_value <= v;
		@(posedge clk);
		result_valid <= 1'b0;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_reset;
		rdc(8'h52, 16'h0000);
		rdc(8'h5A, 16'h0000);
		$display("test_reset done");
	endtask
	task automatic test_cells;
		bus(1'b1, 8'h63, 16'h0064);
		bus(1'b1, 8'h64, 16'h00C8);
		store(1'b0, 4'h0, 16'h0032);
		store(1'b0, 4'hF, 16'h012C);
		rdc(8'h54, 16'h0001);
		rdc(8'h56, 16'h8000);
		rdc(8'h52, 16'hC000);
		bus(1'b1, 8'h54, 16'hFFFE);
		rdc(8'h54, 16'h0001);
		bus(1'b1, 8'h54, 16'h0001);
		rdc(8'h54, 16'h0000);
		rdc(8'h52, 16'h4000);
		store(1'b0, 4'hF, 16'h0096);
		rdc(8'h56, 16'h8000);
		bus(1'b1, 8'h52, 16'h4000);
		rdc(8'h56, 16'h0000);
		rdc(8'h52, 16'h0000);
		$display("test_cells done");
	endtask
	task automatic test_aux;
		bus(1'b1, 8'h68, 16'h0064);
		bus(1'b1, 8'h77, 16'h00C8);
		store(1'b1, 4'h0, 16'h0032);
		store(1'b1, 4'h7, 16'h012C);
		rdc(8'h58, 16'h0180);
		rdc(8'h52, 16'h3000);
		bus(1'b1, 8'h60, 16'h0001);
		store(1'b1, 4'h0, 16'h0096);
		store(1'b1, 4'h7, 16'h0096);
		rdc(8'h58, 16'h0000);
		rdc(8'h52, 16'h0000);
		$display("test_aux done");
	endtask
	// Auto-clear is on here; an analog fault elsewhere must hold the flag
	task automatic test_cmp;
		cmp_low <= 16'h0008;
		cmp_high <= 1'b1;
		repeat (4) @(posedge clk);
		cmp_low <= 16'h0000;
		repeat (4) @(posedge clk);
		rdc(8'h5A, 16'h0008);
		rdc(8'h52, 16'h0C00);
		cmp_high <= 1'b0;
		repeat (4) @(posedge clk);
		rdc(8'h5A, 16'h0000);
		sys_an <= 4'h1;
		cmp_low <= 16'h0008;
		repeat (4) @(posedge clk);
		cmp_low <= 16'h0000;
		repeat (4) @(posedge clk);
		rdc(8'h5A, 16'h0008);
		bus(1'b1, 8'h52, 16'h0800);
		rdc(8'h5A, 16'h0000);
		sys_an <= 4'h0;
		$display("test_cmp done");
	endtask
	task automatic test_ext;
		for (int i = 0; i < 4; i++) begin
			ext <= 4'h1 << i;
			rdc(8'h52, 16'h0040 << i);
		end
		ext <= 4'h0;
		bus(1'b1, 8'h52, 16'h07FF);
		// Pulse stands in the cycle after the accepting edge
		@(posedge clk);
		chk({11'h000, cat_clr}, 16'h001F);
		rdc(8'h53, 16'h0000);
		$display("test_ext done");
	endtask
	// Earlier scenarios leave status bits set; start from a clean status
	task automatic test_irq;
		bus(1'b1, 8'h61, 16'h001F);
		rdc(8'h61, 16'h0000);
		bus(1'b1, 8'h62, 16'h0001);
		store(1'b0, 4'h2, 16'h0032);
		repeat (3) @(posedge clk);
		chk({15'h0000, irq}, 16'h0001);
		bus(1'b1, 8'h61, 16'h0001);
		repeat (3) @(posedge clk);
		chk({15'h0000, irq}, 16'h0000);
		bus(1'b1, 8'h62, 16'h0000);
		store(1'b0, 4'h3, 16'h0032);
		rdc(8'h61, 16'h0001);
		chk({15'h0000, irq}, 16'h0000);
		store(1'b0, 4'h2, 16'h0096);
		rdc(8'h54, 16'h0008);
		$display("test_irq done");
	endtask
	initial begin
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		test_reset();
		test_cells();
		test_aux();
		test_cmp();
		test_ext();
		test_irq();
		tally_and_finish();
	end
endmodule
